// ### include/ctrl_one_defines.svh
// Offsets, field positions, reset values and codes of the first control register.
// Assumes nothing; definitions only.
`ifndef CTRL_ONE_DEFINES_SVH
`define CTRL_ONE_DEFINES_SVH

`define CS1_OFFSET          5'h00
`define CS1_RESET           8'h00
`define CS1_BIT_TEST        7
`define CS1_BIT_SR_HI       6
`define CS1_BIT_STOP        5
`define CS1_BIT_RST_HI      4
`define CS1_BIT_RST_LO      3
`define CS1_BIT_CIE         2
`define CS1_BIT_HOUR12      1
`define CS1_BIT_FIXED_ZERO  0
`define CS1_SOFT_RESET_CODE 8'h58
`define CS1_RST_FIELD_GO    2'h3
`define DIV_STAGES          15
`define DIV_FIRST_HELD      2

`endif

// ### include/ctrl_one_pkg.sv
// Types shared by the first control register and its surroundings.
// Assumes the defines header for all numbers.
package ctrl_one_pkg;

  typedef struct packed {
    logic test_mode;
    logic div_halt;
    logic compensation_pulse_enable;
    logic hour_12_mode;
  } ctrl_one_s;

  typedef logic [7:0] byte_t;

endpackage

// ### rtl/control_status_one.sv
// First control and status register of the clock, with the divider chain it steers.
// Assumes a serial host interface that presents byte accesses on the register port,
// and the 32.768 kHz oscillator arriving as an unsynchronised level.
`timescale 1ns/1ps
`include "ctrl_one_defines.svh"

// Overview of operation
// - Bit 7 set selects external clock test mode
// - Writing 58h acts as software reset command
// - Reset field 4:3 equal 11 starts reset
// - Reset bits always read back as zero
// - Reset field 00 leaves device running normally
// - Halt bit 5 stops timekeeping while set
// - Halt holds prescaler stages F2..F14 at zero
// - Low clock-out frequencies keep running while halted
module control_status_one
  import ctrl_one_pkg::*;
#(
  parameter int DIV_STAGES = `DIV_STAGES
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [4:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       osc_in,
  input  wire logic       test_clk_in,
  output logic            clkout_32k,
  output logic            clkout_16k,
  output logic            clkout_8k,
  output logic            second_tick,
  output logic            time_running,
  output logic            test_mode,
  output logic            compensation_pulse_enable,
  output logic            hour_12_mode,
  output logic            soft_reset_pulse
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation

  logic [1:0] pins_s;

  sync_2ff #(
    .WIDTH (2)
  ) u_pin_sync (
    .clk      (clk),
    .nrst     (nrst),
    .async_in ({test_clk_in, osc_in}),
    .sync_out (pins_s)
  );

  logic osc_s;
  logic test_s;
  assign osc_s  = pins_s[0];
  assign test_s = pins_s[1];

  ////////////////////////////////////////////////////////////////////////////
  // Register

  ctrl_one_s cfg_reg;
  ctrl_one_s cfg_next;
  byte_t     rdata_reg;
  byte_t     rdata_next;
  logic      srst_reg;
  logic      srst_next;
  logic      hit_wr;
  logic      reset_cmd;

  assign hit_wr    = reg_wr && (reg_addr == `CS1_OFFSET);
  // Any write with the field at 11 resets unless srst_reg is already set; the 58h command is one such value,
  // so software that sends exactly that byte gets a reset except in the cycle right after another reset command
  assign reset_cmd = hit_wr &&
                     (reg_wdata[`CS1_BIT_RST_HI:`CS1_BIT_RST_LO] == `CS1_RST_FIELD_GO);

  always_comb
  begin
    cfg_next   = cfg_reg;
    rdata_next = rdata_reg;
    srst_next  = 1'b0;
    if (!nrst || srst_reg)
    begin
      cfg_next = ctrl_one_s'(4'h0);
    end
    else if (reset_cmd)
    begin
      // Reset write stores nothing; the whole register clears next cycle
      srst_next = 1'b1;
    end
    else if (hit_wr)
    begin
      // Field 00 or a single 1 is simply not a reset
      cfg_next.test_mode                 = reg_wdata[`CS1_BIT_TEST];
      cfg_next.div_halt                  = reg_wdata[`CS1_BIT_STOP];
      cfg_next.compensation_pulse_enable = reg_wdata[`CS1_BIT_CIE];
      cfg_next.hour_12_mode              = reg_wdata[`CS1_BIT_HOUR12];
    end
    if (!nrst)
    begin
      rdata_next = `CS1_RESET;
    end
    else if (reg_rd)
    begin
      rdata_next = `CS1_RESET;
      if (reg_addr == `CS1_OFFSET)
      begin
        // Reset request bits and the fixed zero bit always read as 0
        rdata_next[`CS1_BIT_TEST]   = cfg_reg.test_mode;
        rdata_next[`CS1_BIT_STOP]   = cfg_reg.div_halt;
        rdata_next[`CS1_BIT_CIE]    = cfg_reg.compensation_pulse_enable;
        rdata_next[`CS1_BIT_HOUR12] = cfg_reg.hour_12_mode;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    cfg_reg   <= cfg_next;
    rdata_reg <= rdata_next;
    srst_reg  <= srst_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Divider chain

  logic [DIV_STAGES-1:0] div_reg;
  logic [DIV_STAGES-1:0] div_next;
  logic                  osc_d_reg;
  logic                  osc_d_next;
  logic                  test_d_reg;
  logic                  test_d_next;
  logic                  adv;
  logic                  sec_next;
  logic                  out32_next;
  logic [DIV_STAGES-1:0] lower_mask;

  assign lower_mask = DIV_STAGES'((1 << `DIV_FIRST_HELD) - 1);

  // Test mode clocks the chain from the external pin instead of the oscillator
  assign adv = cfg_reg.test_mode ? (test_s && !test_d_reg)
                                 : (osc_s && !osc_d_reg);

  always_comb
  begin
    div_next    = div_reg;
    sec_next    = 1'b0;
    out32_next  = osc_s;
    // Edge history follows only the pin reset, so a soft reset cannot fake an edge
    osc_d_next  = nrst ? osc_s : 1'b0;
    test_d_next = nrst ? test_s : 1'b0;
    if (!nrst || srst_reg)
    begin
      div_next   = '0;
      out32_next = 1'b0;
    end
    else
    begin
      if (adv)
      begin
        div_next = div_reg + DIV_STAGES'(1);
        sec_next = !cfg_reg.div_halt && (div_reg == {DIV_STAGES{1'b1}});
      end
      // Halt clears the upper stages every cycle; F0 and F1 keep dividing
      if (cfg_reg.div_halt)
      begin
        div_next = div_next & lower_mask;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    div_reg     <= div_next;
    osc_d_reg   <= osc_d_next;
    test_d_reg  <= test_d_next;
    second_tick <= sec_next;
    clkout_32k  <= out32_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Every pin leaves from a flop; all of them sit at 0 while nrst is low
  logic clk16_next;
  logic clk8_next;
  logic run_next;
  logic test_out_next;
  logic cie_out_next;
  logic hour_out_next;
  logic srst_out_next;

  always_comb
  begin
    clk16_next    = 1'b0;
    clk8_next     = 1'b0;
    run_next      = 1'b0;
    test_out_next = 1'b0;
    cie_out_next  = 1'b0;
    hour_out_next = 1'b0;
    srst_out_next = 1'b0;
    if (nrst)
    begin
      clk16_next    = div_reg[0];
      clk8_next     = div_reg[1];
      run_next      = !cfg_reg.div_halt;
      test_out_next = cfg_reg.test_mode;
      cie_out_next  = cfg_reg.compensation_pulse_enable;
      hour_out_next = cfg_reg.hour_12_mode;
      srst_out_next = srst_next;
    end
  end

  always_ff @(posedge clk)
  begin
    clkout_16k                <= clk16_next;
    clkout_8k                 <= clk8_next;
    time_running              <= run_next;
    test_mode                 <= test_out_next;
    compensation_pulse_enable <= cie_out_next;
    hour_12_mode              <= hour_out_next;
    soft_reset_pulse          <= srst_out_next;
  end

  assign reg_rdata = rdata_reg;

endmodule

// ### rtl/sync_2ff.sv
// Two flip-flop synchroniser for levels from outside the clock domain.
// Assumes inputs are slow compared with clk.
`timescale 1ns/1ps

module sync_2ff #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  always_comb
  begin
    meta_next = nrst ? async_in : '0;
    sync_next = nrst ? meta_reg : '0;
  end

  always_ff @(posedge clk)
  begin
    meta_reg <= meta_next;
    sync_reg <= sync_next;
  end

  assign sync_out = sync_reg;

endmodule

// ### sim/control_status_one_properties.sv
// Checker of the first control register, bound to its top module.
// Assumes the oscillator input toggles within a few tens of clk cycles.
`timescale 1ns/1ps
module control_status_one_properties (
  input logic       clk,
  input logic       nrst,
  input logic [4:0] reg_addr,
  input logic       reg_wr,
  input logic [7:0] reg_wdata,
  input logic       reg_rd,
  input logic [7:0] reg_rdata,
  input logic       clkout_16k,
  input logic       second_tick,
  input logic       time_running,
  input logic       test_mode,
  input logic       hour_12_mode,
  input logic       soft_reset_pulse
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_cmd;
    reg_wr && reg_addr == 5'h00 && reg_wdata[4:3] == 2'b11;
  endsequence
  // A write just after a reset command is lost, so it is left out
  sequence s_cfg;
    reg_wr && reg_addr == 5'h00 && reg_wdata[4:3] != 2'b11 && !soft_reset_pulse;
  endsequence
  a_reset_cmd_pulse: assert property (s_cmd |=> soft_reset_pulse)
    else $error("no reset pulse after command");
  a_idle_field_quiet: assert property (s_cfg and reg_wdata[4:3] == 2'b00 |=> !soft_reset_pulse)
    else $error("reset pulse without command");
  a_read_hides_bits: assert property (reg_rd |=> reg_rdata[6] == 1'b0 && reg_rdata[4:3] == 2'b00)
    else $error("reset bits visible on read");
  a_halt_no_tick: assert property (!time_running |-> !second_tick)
    else $error("tick while halted");
  a_test_bit_set: assert property (s_cfg ##2 1 |-> test_mode == $past(reg_wdata[7], 2))
    else $error("test mode differs from written bit");
  a_halt_bit_set: assert property (s_cfg ##2 1 |-> time_running == !$past(reg_wdata[5], 2))
    else $error("running state differs from halt bit");
  a_hour_bit_set: assert property (s_cfg ##2 1 |-> hour_12_mode == $past(reg_wdata[1], 2))
    else $error("hour mode differs from written bit");
  a_reset_clears_cfg: assert property (soft_reset_pulse |-> ##2 !test_mode && !hour_12_mode)
    else $error("config kept after reset");
  a_slow_clk_live: assert property (!time_running |-> ##[0:60] $changed(clkout_16k))
    else $error("low clock output stuck while halted");
endmodule
bind control_status_one control_status_one_properties chk (.*);

// ### sim/control_status_one_tb.sv
// Self-checking bench of the first control register.
// Assumes a fast stand-in oscillator and a shortened divider chain.
`timescale 1ns/1ps
module control_status_one_tb;
  import ctrl_one_pkg::*;
  logic clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, osc_in = 0, test_clk_in = 0;
  logic [4:0] reg_addr = 5'h00;
  byte_t reg_wdata = 8'h00, reg_rdata;
  logic clkout_32k, clkout_16k, clkout_8k, second_tick, time_running;
  logic test_mode, compensation_pulse_enable, hour_12_mode, soft_reset_pulse;
  int num_errors = 0, compares = 0, pulses = 0, ticks = 0, flips = 0;
  int flips32 = 0, flips8 = 0;
  logic last16 = 1'b0, last32 = 1'b0, last8 = 1'b0;
  control_status_one #(
    .DIV_STAGES (4)
  ) dut (
    .clk                       (clk),
    .nrst                      (nrst),
    .reg_addr                  (reg_addr),
    .reg_wr                    (reg_wr),
    .reg_wdata                 (reg_wdata),
    .reg_rd                    (reg_rd),
    .reg_rdata                 (reg_rdata),
    .osc_in                    (osc_in),
    .test_clk_in               (test_clk_in),
    .clkout_32k                (clkout_32k),
    .clkout_16k                (clkout_16k),
    .clkout_8k                 (clkout_8k),
    .second_tick               (second_tick),
    .time_running              (time_running),
    .test_mode                 (test_mode),
    .compensation_pulse_enable (compensation_pulse_enable),
    .hour_12_mode              (hour_12_mode),
    .soft_reset_pulse          (soft_reset_pulse)
  );
  always #2 clk = ~clk;
  always #40 osc_in = ~osc_in;
  always #60 test_clk_in = ~test_clk_in;
  always @(posedge clk)
  begin
    pulses += (soft_reset_pulse === 1'b1);
    ticks += (second_tick === 1'b1);
    flips += (clkout_16k !== last16);
    flips32 += (clkout_32k !== last32);
    flips8 += (clkout_8k !== last8);
    last16 <= clkout_16k;
    last32 <= clkout_32k;
    last8 <= clkout_8k;
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input byte_t got, input byte_t exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input byte_t d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [4:0] a, input byte_t exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    #1 chk(reg_rdata, exp);
  endtask
  task automatic conclude;
    $display("errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic halt_and_modes;
    wr(5'h00, 8'hE7);
    chk({4'h0, test_mode, time_running, hour_12_mode, compensation_pulse_enable}, 8'h0B);
    rd(5'h00, 8'hA6);
    ticks = 0;
    flips = 0;
    flips32 = 0;
    flips8 = 0;
    repeat (400) @(posedge clk);
    chk(8'(ticks), 8'h00);
    // Test clock rises every 30 cycles here, the oscillator every 20
    chk(8'(flips > 8 && flips < 16), 8'h01);
    chk(8'(flips32 > 30), 8'h01);
    chk(8'(flips8 > 2), 8'h01);
    wr(5'h01, 8'hFF);
    rd(5'h01, 8'h00);
    rd(5'h00, 8'hA6);
  endtask
  task automatic reset_field;
    chk(8'(pulses), 8'h00);
    wr(5'h00, 8'h10);
    chk(8'(pulses), 8'h00);
    rd(5'h00, 8'h00);
    wr(5'h00, 8'h82);
    chk({6'h00, test_mode, hour_12_mode}, 8'h03);
    wr(5'h00, 8'h58);
    chk(8'(pulses), 8'h01);
    repeat (2) @(posedge clk);
    #1 chk({6'h00, test_mode, hour_12_mode}, 8'h00);
    rd(5'h00, 8'h00);
  endtask
  task automatic running;
    wr(5'h00, 8'h00);
    ticks = 0;
    repeat (800) @(posedge clk);
    // Four stages wrap every 320 cycles; the chain restarted at the soft reset, so this window holds two ticks
    chk(8'(ticks), 8'h02);
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    rd(5'h00, 8'h00);
    halt_and_modes;
    reset_field;
    running;
    conclude;
  end
  initial
  begin
    #40000;
    num_errors++;
    conclude;
  end
endmodule
